// *** src/boot_mode_select_reset.sv ***
// boot source selection, reset sequencing and image loading
//
// Contract
// RULE1: boot runs after power-up and every reset
// RULE2: select high gives spi slave boot
// RULE3: select on flash line gives quad master
// RULE4: quad master uses cs, four data, shared clock
// RULE5: power-on reset holds device until supplies up
// RULE6: reset pin active low, release starts boot
// RULE7: external clock 24MHz, running at reset release; code assumes CLK_HZ of 10 MHz
// RULE8: slave boot bytes arrive lsb first
// RULE9: quad bytes carry lower nibble first
// RULE10: flash read uses 0xeb plus one dummy
// RULE11: select sampled once at release, then held
`timescale 1ns/100ps
module boot_mode_select_reset #(
  parameter int unsigned IMAGE_BYTES = boot_pkg::IMAGE_BYTES_DEF
) (
  input  wire logic        i_clk,            // system clock, assumed running at release
  input  wire logic        i_rst_n,          // device reset pin, active low
  input  wire logic        i_supply_good,    // supplies up, from the power monitor
  // shared clock pin: slave clock in, flash clock out
  input  wire logic        i_spi_clk,
  output logic             o_spi_clk,
  output logic             o_spi_clk_oe,
  // host spi slave pins
  input  wire logic        i_spi_cs_n,
  input  wire logic        i_spi_mosi,
  output logic             o_spi_miso,
  // flash pins
  output logic             o_flash_cs_n,
  output logic             o_flash_cs_n_oe,
  input  wire logic        i_flash_data0,
  input  wire logic        i_boot_select_flash_data1,
  input  wire logic        i_flash_data2,
  input  wire logic        i_flash_data3,
  output logic [3:0]       o_flash_data,
  output logic [3:0]       o_flash_data_oe,
  // image byte stream and status
  output logic [7:0]       o_image_data,
  output logic             o_image_valid,
  output logic             o_boot_mode_slave,
  output logic             o_boot_done,
  output logic             o_core_rst_n
);
  import boot_pkg::*;

  initial begin
    if (IMAGE_BYTES < 1 || IMAGE_BYTES > 65535) $error("IMAGE_BYTES out of range");
  end

  // ==========================================================
  // power-on and pin reset
  // ==========================================================
  logic        rst_sync_n;                   // supply good and pin, released synchronously
  logic [1:0]  rst_pipe;                      // release pipeline
  logic [7:0]  por_cnt;                       // hold count after release
  logic        started;                       // mode captured, boot running

  // either cause clears the device; release is synchronised to the clock
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_pipe <= 2'h0;                       // RULE6
    end else begin
      rst_pipe <= {rst_pipe[0], i_supply_good}; // RULE5
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // short hold after release so the select pin has settled
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      por_cnt <= 8'h00;
    end else if (!rst_sync_n) begin
      por_cnt <= 8'h00;                        // RULE5
    end else if (por_cnt < 8'(POR_HOLD_CYC)) begin
      por_cnt <= por_cnt + 8'h01;
    end
  end

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [6:0] pins_s;
  sync2 #(.WIDTH(7)) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async ({i_spi_clk, i_spi_cs_n, i_spi_mosi, i_flash_data3, i_flash_data2,
               i_boot_select_flash_data1, i_flash_data0}),
    .o_sync  (pins_s)
  );
  logic       sclk_s;
  logic       cs_n_s;
  logic       mosi_s;
  logic [3:0] fdata_s;
  assign sclk_s  = pins_s[6];
  assign cs_n_s  = pins_s[5];
  assign mosi_s  = pins_s[4];
  assign fdata_s = pins_s[3:0];

  // ==========================================================
  // boot mode capture
  // ==========================================================
  boot_mode_t mode;                            // chosen boot source

  // caught once when the hold ends; flash drives line 1 low-ish idle, pull-up means host
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode    <= BOOT_FLASH;
      started <= 1'b0;
    end else if (!rst_sync_n) begin
      started <= 1'b0;                         // RULE1
    end else if (!started && por_cnt == 8'(POR_HOLD_CYC)) begin
      started <= 1'b1;                         // RULE11
      mode    <= fdata_s[1] ? BOOT_SLAVE : BOOT_FLASH; // RULE2 RULE3
    end
  end

  assign o_boot_mode_slave = (mode == BOOT_SLAVE);
  assign o_core_rst_n      = rst_sync_n && o_boot_done;

  // ==========================================================
  // spi slave receiver
  // ==========================================================
  logic       sclk_d;                          // previous sampled clock
  logic [7:0] slv_shift;                       // incoming byte
  logic [2:0] slv_bits;                        // bits collected
  logic       slv_byte;                        // byte complete pulse
  logic       slv_active;

  assign slv_active = started && mode == BOOT_SLAVE && !o_boot_done;

  // sample mosi on rising clock while selected; bit 0 arrives first
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_d    <= 1'b0;
      slv_shift <= 8'h00;
      slv_bits  <= 3'h0;
      slv_byte  <= 1'b0;
    end else begin
      sclk_d   <= sclk_s;
      slv_byte <= 1'b0;
      if (!slv_active || cs_n_s) begin
        slv_bits <= 3'h0;                      // deselect drops a partial byte
      end else if (sclk_s && !sclk_d) begin
        slv_shift <= {mosi_s, slv_shift[7:1]}; // RULE8
        slv_bits  <= slv_bits + 3'h1;
        slv_byte  <= (slv_bits == 3'h7);
      end
    end
  end
  assign o_spi_miso = 1'b0;                    // nothing returned during boot

  // ==========================================================
  // quad spi master
  // ==========================================================
  qspi_state_t q_state;
  logic [1:0]  q_div;                          // half period counter
  logic        q_clk;                          // flash clock level
  logic [31:0] q_tx;                           // command or address shift
  logic [5:0]  q_cnt;                          // bits or nibbles left in phase
  logic [15:0] q_bytes;                        // image bytes left
  logic [3:0]  q_lo;                           // held lower nibble
  logic        q_half;                         // upper nibble pending
  logic        q_byte;                         // byte complete pulse
  logic [7:0]  q_data;
  logic        q_tick;

  assign q_tick = (q_div == 2'(FLASH_HALF_CYC - 1));

  // sequencer: opcode serial on line 0, then quad address, dummy, data
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_state <= Q_IDLE;
      q_div   <= 2'h0;
      q_clk   <= 1'b0;
      q_tx    <= 32'h0;
      q_cnt   <= 6'h0;
      q_bytes <= 16'h0;
      q_lo    <= 4'h0;
      q_half  <= 1'b0;
      q_byte  <= 1'b0;
      q_data  <= 8'h00;
    end else if (!rst_sync_n) begin
      q_state <= Q_IDLE;
      q_clk   <= 1'b0;
      q_byte  <= 1'b0;
    end else begin
      q_byte <= 1'b0;
      q_div  <= q_tick ? 2'h0 : q_div + 2'h1;
      unique case (q_state)
        Q_IDLE: begin
          if (started && mode == BOOT_FLASH) begin
            q_state <= Q_CMD;
            q_tx    <= {FAST_QUAD_READ, IMAGE_START_ADDR}; // RULE10
            q_cnt   <= 6'd8;
            q_clk   <= 1'b0;
          end
        end
        default: begin
          if (q_tick && q_state != Q_DONE) begin
            q_clk <= ~q_clk;
            if (q_clk) begin
              // falling edge: advance outgoing data
              q_cnt <= q_cnt - 6'h1;
              if (q_state == Q_CMD) begin
                q_tx <= {q_tx[30:0], 1'b0};
                if (q_cnt == 6'h1) begin
                  q_state <= Q_ADDR;
                  q_cnt   <= 6'(ADDR_BYTES * 2);
                end
              end else if (q_state == Q_ADDR) begin
                q_tx <= {q_tx[27:0], 4'h0};
                if (q_cnt == 6'h1) begin
                  q_state <= Q_DUMMY;
                  q_cnt   <= 6'(DUMMY_BYTES * 2); // RULE10
                end
              end else if (q_state == Q_DUMMY && q_cnt == 6'h1) begin
                q_state <= Q_DATA;
                q_bytes <= 16'(IMAGE_BYTES);
                q_half  <= 1'b0;
              end
            end else if (q_state == Q_DATA) begin
              // rising edge: capture a nibble, lower half first
              if (!q_half) begin
                q_lo   <= fdata_s;              // RULE9
                q_half <= 1'b1;
              end else begin
                q_data  <= {fdata_s, q_lo};     // RULE9
                q_byte  <= 1'b1;
                q_half  <= 1'b0;
                q_bytes <= q_bytes - 16'h1;
                if (q_bytes == 16'h1) begin
                  q_state <= Q_DONE;
                  q_clk   <= 1'b0;
                end
              end
            end
          end
        end
      endcase
    end
  end

  // flash pins: cs low through the read, shared clock pin driven only in flash mode
  logic q_busy;
  assign q_busy          = (q_state != Q_IDLE) && (q_state != Q_DONE);
  assign o_flash_cs_n    = !q_busy;                                   // RULE4
  assign o_flash_cs_n_oe = started && mode == BOOT_FLASH;
  assign o_spi_clk       = q_clk;
  assign o_spi_clk_oe    = started && mode == BOOT_FLASH;             // RULE4
  // address nibbles leave from the top of the shifter, the same end the opcode bits use
  assign o_flash_data    = (q_state == Q_CMD) ? {3'h0, q_tx[31]} : q_tx[31:28];
  assign o_flash_data_oe = (q_state == Q_CMD) ? 4'h1 : (q_state == Q_ADDR) ? 4'hf : 4'h0;

  // ==========================================================
  // image stream and completion
  // ==========================================================
  logic [15:0] slv_count;                      // host bytes received

  // one byte stream from whichever source is active
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_image_data  <= 8'h00;
      o_image_valid <= 1'b0;
      slv_count     <= 16'h0;
      o_boot_done   <= 1'b0;
    end else if (!rst_sync_n) begin
      o_image_valid <= 1'b0;
      slv_count     <= 16'h0;
      o_boot_done   <= 1'b0;                   // RULE1
    end else begin
      o_image_valid <= slv_byte || q_byte;
      if (slv_byte) begin
        o_image_data <= slv_shift;
        slv_count    <= slv_count + 16'h1;
        if (slv_count == 16'(IMAGE_BYTES - 1)) o_boot_done <= 1'b1;
      end else if (q_byte) begin
        o_image_data <= q_data;
      end
      if (q_state == Q_DONE) o_boot_done <= 1'b1;
    end
  end
endmodule

// *** src/boot_pkg.sv ***
// constants and types shared by the boot loader files
package boot_pkg;
  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ            = 10_000_000;   // system clock rate
  localparam int unsigned POR_HOLD_NS       = 1000;         // power-on hold time
  localparam int unsigned POR_HOLD_CYC      = (POR_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FLASH_HALF_CYC    = 2;            // system clocks per flash clock half period

  // ==========================================================
  // flash command sequence
  // ==========================================================
  localparam logic [7:0]  FAST_QUAD_READ    = 8'heb;        // quad read opcode
  localparam int unsigned ADDR_BYTES        = 3;            // address bytes
  localparam int unsigned DUMMY_BYTES       = 1;            // dummy bytes before data
  localparam logic [23:0] IMAGE_START_ADDR  = 24'h000000;   // image start in flash
  localparam int unsigned IMAGE_BYTES_DEF   = 64;           // default image length

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic {
    BOOT_FLASH,                                              // quad master from local flash
    BOOT_SLAVE                                               // spi slave from host
  } boot_mode_t;

  typedef enum {
    Q_IDLE,
    Q_CMD,
    Q_ADDR,
    Q_DUMMY,
    Q_DATA,
    Q_DONE
  } qspi_state_t;
endpackage

// *** src/sync2.sv ***
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
module sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  // ==========================================================
  // two stages
  // ==========================================================
  logic [WIDTH-1:0] meta;   // first stage, read only by the second

  // first stage catches the pin, second gives a settled level
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// *** verif/boot_monitor.sv ***
// port checker for the boot loader, bound into its top module
`timescale 1ns/100ps
module boot_monitor #(
  parameter int unsigned IMAGE_BYTES = boot_pkg::IMAGE_BYTES_DEF
) (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_supply_good,
  input wire logic       o_spi_clk,
  input wire logic       o_spi_clk_oe,
  input wire logic       o_flash_cs_n,
  input wire logic [3:0] o_flash_data_oe,
  input wire logic       o_image_valid,
  input wire logic       o_boot_mode_slave,
  input wire logic       o_boot_done,
  input wire logic       o_core_rst_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // byte pulses since boot start, cleared while supplies are down
  logic [7:0] n_bytes;  // count of valid pulses
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) n_bytes <= 8'h00;
    else if (!i_supply_good) n_bytes <= 8'h00;
    else if (o_image_valid) n_bytes <= n_bytes + 8'h01;
  end
  // ==========================================================
  // properties
  a_pulse_single: assert property (o_image_valid |=> !o_image_valid)
    else $error("image valid held over one cycle");
  a_count_match: assert property ($rose(o_boot_done) |-> n_bytes + 8'(o_image_valid) == 8'(IMAGE_BYTES))
    else $error("boot done after wrong byte count");
  a_done_quiet: assert property (o_boot_done && $past(o_boot_done) |-> !o_image_valid)
    else $error("byte delivered after boot done");
  a_core_gate: assert property (o_core_rst_n |-> o_boot_done)
    else $error("core released before boot done");
  a_supply_hold: assert property (!i_supply_good |-> ##4 !o_core_rst_n)
    else $error("core not held while supplies down");
  a_slave_pins: assert property (o_boot_mode_slave |-> o_flash_cs_n && !o_spi_clk_oe && o_flash_data_oe == 4'h0)
    else $error("flash pins active in host boot");
  a_oe_shape: assert property (o_flash_cs_n |-> o_flash_data_oe == 4'h0 ##0 o_flash_data_oe inside {4'h0, 4'h1, 4'hf})
    else $error("flash data enable pattern wrong");
  a_clk_half: assert property ($rose(o_spi_clk) |-> ##1 o_spi_clk ##1 !o_spi_clk)
    else $error("flash clock high time not two cycles");
  a_mode_held: assert property (o_boot_done && $past(o_boot_done) |-> $stable(o_boot_mode_slave))
    else $error("boot mode changed after boot");
endmodule
bind boot_mode_select_reset boot_monitor #(.IMAGE_BYTES(IMAGE_BYTES)) boot_monitor_i (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_supply_good(i_supply_good), .o_spi_clk(o_spi_clk),
  .o_spi_clk_oe(o_spi_clk_oe), .o_flash_cs_n(o_flash_cs_n), .o_flash_data_oe(o_flash_data_oe),
  .o_image_valid(o_image_valid), .o_boot_mode_slave(o_boot_mode_slave), .o_boot_done(o_boot_done),
  .o_core_rst_n(o_core_rst_n));

// *** verif/far_side_model.sv ***
// host spi master and quad flash standing on the loader's pins
`timescale 1ns/100ps
module far_side_model (
  input  wire logic       i_clk,       // system clock, used to find pin edges
  input  wire logic       i_sel_high,  // strap level on data line 1
  input  wire logic       i_clk_out,   // loader flash clock
  input  wire logic       i_clk_oe,
  input  wire logic       i_cs_n,      // loader flash select
  input  wire logic [3:0] i_dq,
  input  wire logic [3:0] i_dq_oe,
  output logic            o_spi_clk,   // shared clock pin level
  output logic            o_host_cs_n,
  output logic            o_host_mosi,
  output logic [3:0]      o_dq         // flash data pin levels
);
  logic [7:0] img [16];     // flash image, loaded by the bench
  logic [3:0] hdr [16];     // command nibbles seen by the flash
  logic [3:0] hdr_oe [16];  // enables seen with them
  logic [3:0] nib = 4'h0;   // nibble the flash presents
  logic       drv = 1'b0;   // flash drives its data lines
  logic       hclk = 1'b0;  // host clock, stands low outside frames
  logic       prev = 1'b0;  // last flash clock level
  int         edges = 0;    // rising clocks in this frame
  initial o_host_cs_n = 1'b1;
  initial o_host_mosi = 1'b0;
  // ==========================================================
  // pin levels: loader wins, then flash, then pulls
  assign o_spi_clk = i_clk_oe ? i_clk_out : hclk;
  for (genvar b = 0; b < 4; b++) begin : g_pin
    assign o_dq[b] = i_dq_oe[b] ? i_dq[b] : drv ? nib[b] : (b == 1) ? i_sel_high : 1'b0;
  end
  // ==========================================================
  // flash: record header, present data a full clock ahead of its rise
  always @(negedge i_clk) begin
    if (i_cs_n) begin
      edges = 0;
      drv = 1'b0;
    end else if (i_clk_out && !prev) begin
      if (edges < 16) begin  // opcode, address, dummy
        hdr[edges] = i_dq;
        hdr_oe[edges] = i_dq_oe;
      end
      // next nibble goes out one flash clock before the rise that takes it; the loader's pins lag two cycles
      if (edges >= 15) begin
        drv = 1'b1;
        nib = edges[0] ? img[((edges - 15) / 2) % 16][3:0] : img[((edges - 15) / 2) % 16][7:4];  // low first
      end
      edges = edges + 1;
    end
    prev = i_clk_out;
  end
  // ==========================================================
  // host: bits change while the clock is low, 800 ns period
  task automatic host_bits(input logic [7:0] b, input int n);
    for (int k = 0; k < n; k++) begin
      o_host_mosi = b[k];  // lsb first
      #400 hclk = 1'b1;
      #400 hclk = 1'b0;
    end
  endtask
  task automatic host_cs(input logic v);
    #400 o_host_cs_n = v;
    if (v) o_host_mosi = ~o_host_mosi;  // a released line does not hold its value
  endtask
endmodule

// *** verif/tb_boot_mode_select_reset.sv ***
// self-checking bench for the boot loader
`timescale 1ns/100ps
module tb_boot_mode_select_reset;
  import boot_pkg::*;
  localparam int NB = 4;  // short image keeps the run brief
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_supply_good = 1'b1, sel = 1'b0;
  logic i_spi_clk, i_spi_cs_n, i_spi_mosi, o_spi_clk, o_spi_clk_oe, o_spi_miso, o_flash_cs_n, o_flash_cs_n_oe;
  logic [3:0] dq, o_flash_data, o_flash_data_oe;
  logic [7:0] o_image_data, sb [NB];
  logic o_image_valid, o_boot_mode_slave, o_boot_done, o_core_rst_n;
  logic [7:0] got [$];  // bytes delivered by the loader
  int n_errors = 0, cmp_count = 0;
  // ==========================================================
  // clock, design and far side
  always #50 i_clk = ~i_clk;  // running before release
  boot_mode_select_reset #(.IMAGE_BYTES(NB)) boot_mode_select_reset_i (.i_clk, .i_rst_n, .i_supply_good,
    .i_spi_clk, .o_spi_clk, .o_spi_clk_oe, .i_spi_cs_n, .i_spi_mosi, .o_spi_miso, .o_flash_cs_n,
    .o_flash_cs_n_oe, .i_flash_data0(dq[0]), .i_boot_select_flash_data1(dq[1]), .i_flash_data2(dq[2]),
    .i_flash_data3(dq[3]), .o_flash_data, .o_flash_data_oe, .o_image_data, .o_image_valid, .o_boot_mode_slave,
    .o_boot_done, .o_core_rst_n);
  far_side_model far_side_model_i (.i_clk, .i_sel_high(sel), .i_clk_out(o_spi_clk), .i_clk_oe(o_spi_clk_oe),
    .i_cs_n(o_flash_cs_n), .i_dq(o_flash_data), .i_dq_oe(o_flash_data_oe), .o_spi_clk(i_spi_clk),
    .o_host_cs_n(i_spi_cs_n), .o_host_mosi(i_spi_mosi), .o_dq(dq));
  // collect bytes where outputs are settled
  always @(negedge i_clk) if (o_image_valid === 1'b1) got.push_back(o_image_data);
  // ==========================================================
  // expectation and check helpers
  function automatic logic [7:0] exp_hdr(input int k);  // {enables, nibble}
    if (k < 8) return {4'h1, 3'b000, FAST_QUAD_READ[7-k]};
    if (k < 14) return {4'hf, IMAGE_START_ADDR[4*(13-k) +: 4]};
    return 8'h00;
  endfunction
  task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask
  task automatic do_reset(input logic s);
    sel = s;
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_clk);
    check(o_core_rst_n, 0, "core held in reset");
    i_rst_n = 1'b1;
  endtask
  task automatic wait_done(input logic [31:0] slave);
    int t;
    t = 0;
    while (o_boot_done !== 1'b1 && t < 20000) begin
      @(negedge i_clk);
      t++;
    end
    @(negedge i_clk);  // let the byte collector take the last byte first
    check(o_boot_done, 1, "boot done");
    check(o_core_rst_n, 1, "core released");
    check(o_boot_mode_slave, slave, "boot mode");
    check(got.size(), NB, "byte count");
  endtask
  task automatic flash_checks;
    for (int k = 0; k < 16; k++)
      check({far_side_model_i.hdr_oe[k], far_side_model_i.hdr[k] & far_side_model_i.hdr_oe[k]}, exp_hdr(k), "hdr");
    for (int k = 0; k < NB; k++) check(got[k], far_side_model_i.img[k], "flash byte");
    check({o_flash_cs_n, o_flash_cs_n_oe, o_spi_clk_oe}, 3'b111, "flash pins");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog, far beyond the expected run of about 60 us
  initial begin
    #1_000_000;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end
  // ==========================================================
  // tests
  initial begin
    void'($urandom(32'h09fc));
    for (int k = 0; k < 16; k++) far_side_model_i.img[k] = 8'($urandom);
    far_side_model_i.img[0] = 8'hf0;  // nibble order shows at once
    for (int k = 0; k < NB; k++) sb[k] = 8'($urandom);
    sb[0] = 8'h80;  // bit order shows at once
    // flash boot with the strap pulled low
    do_reset(1'b0);
    wait_done(0);
    flash_checks();
    $display("flash boot test done");
    // host boot; strap flips after capture, a partial byte is dropped
    got.delete();
    do_reset(1'b1);
    repeat (20) @(negedge i_clk);
    sel = 1'b0;  // mode must not follow
    far_side_model_i.host_cs(1'b0);
    far_side_model_i.host_bits(8'h5a, 4);
    far_side_model_i.host_cs(1'b1);
    far_side_model_i.host_cs(1'b0);
    for (int k = 0; k < NB; k++) far_side_model_i.host_bits(sb[k], 8);
    far_side_model_i.host_cs(1'b1);
    @(negedge i_clk);
    wait_done(1);
    for (int k = 0; k < NB; k++) check(got[k], sb[k], "host byte");
    check(o_spi_clk_oe, 0, "clock pin input");
    check(o_spi_miso, 0, "host data out idle");
    $display("host boot test done");
    // supply drop resets and reboots from flash
    i_supply_good = 1'b0;
    repeat (10) @(negedge i_clk);
    check({o_core_rst_n, o_boot_done}, 2'b00, "held while supplies down");
    got.delete();
    i_supply_good = 1'b1;
    wait_done(0);
    flash_checks();
    $display("supply restart test done");
    final_report();
  end
endmodule
